// >>> bench/pmbus_status_and_formats_tb.sv
// Self-checking bench of the status and number format block
`timescale 1ns/1ps

module pmbus_status_and_formats_tb;
    logic clk_sys_i, nrst_i, wr, rd, rvalid, nack, alert_n, ok, nk;
    logic [7:0] cmd;
    logic [15:0] wdata, vset, vcal, ical;
    logic [4:0] vexp;
    logic [14:0] tms;
    logic [47:0] rdata, rv;
    psf_pkg::psf_evt_t evt;
    psf_pkg::psf_sum_t sum;
    int fail_count, compares;
    logic [7:0] tc [5] = '{8'h45, 8'h81, 8'hc3, 8'h3f, 8'hc0};
    logic [14:0] tx [5] = '{15'h0028, 15'h0040, 15'h0600, 15'h003f, 15'h0};

    // Clock at 100 MHz
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    psf_status dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_i(cmd),
        .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
        .rvalid_o(rvalid), .nack_o(nack), .evt_i(evt), .sum_i(sum),
        .alert_line_n_o(alert_n), .vout_set_o(vset), .vout_exp_o(vexp),
        .vout_cal_o(vcal), .iout_cal_o(ical), .time_ms_o(tms));

    psf_host_model host (.clk_sys_i(clk_sys_i), .cmd_o(cmd), .wr_o(wr),
        .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid),
        .nack_i(nack));

    // Compare and count
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time,
                     seen, exp);
        end
    endtask

    // Read a code and compare its data and answer strobe
    task automatic rdchk(input logic [7:0] c, input logic [47:0] exp);
        host.do_rd(c, rv, ok, nk);
        chk(rv, exp);
        chk(ok, 1'b1);
    endtask

    // One-cycle event pulse
    task automatic pulse(input psf_pkg::psf_evt_t e);
        @(posedge clk_sys_i);
        #1;
        evt = e;
        @(posedge clk_sys_i);
        #1;
        evt = '0;
    endtask

    // Verdict and end of run
    task automatic conclude();
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        fail_count++;
        conclude();
    end

    // Main sequence
    initial begin
        psf_pkg::psf_evt_t e;
        fail_count = 0;
        compares = 0;
        evt = '0;
        sum = '0;
        nrst_i = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        #1;
        nrst_i = 1'b1;
        chk(alert_n, 1'b1);
        rdchk(8'he0, 48'h0);
        // Current fault: detail byte, summary word and alert
        e = '0;
        e.iout = 8'h80;
        pulse(e);
        rdchk(8'he2, 48'h80);
        rdchk(8'he0, 48'h4011);
        chk(alert_n, 1'b0);
        host.do_wr(8'h03, 16'h0, nk);
        chk(alert_n, 1'b1);
        rdchk(8'he2, 48'h0);
        // Input fault 1, new log and watchdog in the wide register
        e = '0;
        e.ext = 48'h0000_0001_1800;
        pulse(e);
        rdchk(8'he5, 48'h0000_0001_1800);
        rdchk(8'he0, 48'h1001);
        host.do_wr(8'h03, 16'h0, nk);
        // Summary levels
        sum.pg_n = 1'b1;
        sum.busy = 1'b1;
        rdchk(8'he0, 48'h0881);
        chk(alert_n, 1'b0);
        sum = '0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(alert_n, 1'b1);
        // Exponent and fixed mode bits
        host.do_wr(8'h20, 16'h001b, nk);
        chk(vexp, 5'h1b);
        rdchk(8'h20, 48'h1b);
        host.do_wr(8'h20, 16'h00ff, nk);
        rdchk(8'h20, 48'h1f);
        // Voltage set, out-of-range refusal and boundary
        host.do_wr(8'h21, 16'h1234, nk);
        chk(vset, 16'h1234);
        rdchk(8'h21, 48'h1234);
        host.do_wr(8'h21, 16'hf001, nk);
        chk(nk, 1'b0);
        chk(vset, 16'h1234);
        rdchk(8'he4, 48'h40);
        chk(alert_n, 1'b0);
        host.do_wr(8'h03, 16'h0, nk);
        host.do_wr(8'h21, 16'hf000, nk);
        chk(vset, 16'hf000);
        // Signed calibration offset and clamp
        host.do_wr(8'h23, 16'hfffe, nk);
        chk(vcal, 16'hfffe);
        host.do_wr(8'h23, 16'h7000, nk);
        chk(vcal, 16'h0400);
        // General linear value: 3 times 2 to the 2, then negative
        host.do_wr(8'h39, 16'h1003, nk);
        chk(ical, 16'h000c);
        rdchk(8'h39, 48'h000c);
        host.do_wr(8'h39, 16'h07ff, nk);
        chk(ical, 16'h0000);
        // Time codes across all multipliers and a zero mantissa
        for (int i = 0; i < 5; i++) begin
            host.do_wr(8'he6, {8'h00, tc[i]}, nk);
            chk(tms, tx[i]);
            rdchk(8'he7, {33'h0, tx[i]});
        end
        // Refused write to status and read of unknown code
        host.do_wr(8'he0, 16'h0, nk);
        chk(nk, 1'b1);
        host.do_rd(8'h7f, rv, ok, nk);
        chk(nk, 1'b1);
        chk(ok, 1'b0);
        rdchk(8'he4, 48'h80);
        host.do_wr(8'h03, 16'h0, nk);
        chk(alert_n, 1'b1);
        // Voltage and temperature detail, reserved temperature bits masked
        e = '0;
        e.vout = 8'h80;
        e.temp = 8'hff;
        pulse(e);
        rdchk(8'he1, 48'h80);
        rdchk(8'he3, 48'hf0);
        rdchk(8'he0, 48'h8025);
        // Reset in mid-run clears status and parameters
        nrst_i = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        nrst_i = 1'b1;
        chk(alert_n, 1'b1);
        chk({vset, vcal, ical}, 48'h0);
        chk(vexp, 5'h00);
        rdchk(8'he0, 48'h0);
        conclude();
    end
endmodule

// >>> bench/psf_host_model.sv
// Host controller model driving the command port of the status block
`timescale 1ns/1ps

module psf_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Requests to the block
    output logic [7:0] cmd_o,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] wdata_o,
    // Answers from the block
    input wire logic [47:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic nack_i
);
    // Idle port at time zero
    initial begin
        cmd_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'h0000;
    end

    // One write strobe; released lines show inverted stale values
    // words sent whole
    task automatic do_wr(input logic [7:0] c, input logic [15:0] d,
                         output logic n);
        @(posedge clk_sys_i);
        #1;
        cmd_o = c;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        wr_o = 1'b0;
        cmd_o = ~c;
        wdata_o = ~d;
        n = nack_i;
    endtask

    // One read strobe; answer taken one cycle after the strobe
    task automatic do_rd(input logic [7:0] c, output logic [47:0] d,
                         output logic v, output logic n);
        @(posedge clk_sys_i);
        #1;
        cmd_o = c;
        rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        rd_o = 1'b0;
        cmd_o = ~c;
        d = rdata_i;
        v = rvalid_i;
        n = nack_i;
    endtask
endmodule

// >>> rtl/psf_defines.svh
// Command codes, field positions, masks and reset values of the status block
`ifndef PSF_DEFINES_SVH
`define PSF_DEFINES_SVH
// Command codes
`define PSF_CMD_CLEAR_FAULTS 8'h03
`define PSF_CMD_VEXP_MODE 8'h20
`define PSF_CMD_VOUT_SET 8'h21
`define PSF_CMD_VOUT_CAL 8'h23
`define PSF_CMD_IOUT_CAL 8'h39
`define PSF_CMD_WORD 8'he0
`define PSF_CMD_VOUT_ST 8'he1
`define PSF_CMD_IOUT_ST 8'he2
`define PSF_CMD_TEMP_ST 8'he3
`define PSF_CMD_CML_ST 8'he4
`define PSF_CMD_EXT_ST 8'he5
`define PSF_CMD_TIME 8'he6
`define PSF_CMD_TIME_MS 8'he7
// Supported-bit masks of the detail registers
`define PSF_VOUT_MASK 8'hff
`define PSF_IOUT_MASK 8'hff
`define PSF_TEMP_MASK 8'hf0
`define PSF_CML_MASK 8'hfb
`define PSF_EXT_MASK 48'hffff_ffff_1f7f
// Field positions
`define PSF_CML_BAD_CMD 7
`define PSF_CML_BAD_DATA 6
`define PSF_EXT_NEW_LOG 12
`define PSF_EXT_SYS_WDOG 11
`define PSF_EXT_INPUT_LSB 16
`define PSF_IOUT_OC 7
`define PSF_VOUT_OV 7
`define PSF_VEXP_W 5
`define PSF_LIN11_MANT_W 11
`define PSF_LIN11_MANT_MAX 1023
`define PSF_TIME_MANT_W 6
// Mode field of the exponent mode register: linear, fixed
`define PSF_VEXP_LINEAR 3'h0
// Reset values
`define PSF_RST_VEXP 5'h00
`define PSF_RST_WORD16 16'h0000
`define PSF_RST_BYTE 8'h00
`endif

// >>> rtl/psf_pkg.sv
// Types of the status and number format block
package psf_pkg;
    typedef struct packed {
        logic input_flt;
        logic pg_n;
        logic fans;
        logic other;
        logic unknown;
        logic busy;
        logic off;
        logic vin_uv;
    } psf_sum_t;

    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] temp;
        logic [7:0] cml;
        logic [47:0] ext;
    } psf_evt_t;

    typedef struct packed {
        psf_evt_t st;
        logic [15:0] word;
        logic [4:0] vexp;
        logic [15:0] vset;
        logic [15:0] vcal;
        logic [15:0] ical;
        logic [7:0] tcode;
        logic [14:0] tms;
        logic [47:0] rdata;
        logic rvalid;
        logic nack;
        logic alert_n;
    } psf_state_t;
endpackage

// >>> rtl/psf_status.sv
// Status registers, alert line and linear number formats of the rail monitor
`timescale 1ns/1ps
`include "psf_defines.svh"

module psf_status #(
    parameter logic [15:0] VOUT_LIMIT = 16'hf000,
    parameter logic [15:0] CAL_LIMIT = 16'h0400
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Command port
    input wire logic [7:0] cmd_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] wdata_i,
    output logic [47:0] rdata_o,
    output logic rvalid_o,
    output logic nack_o,
    // Fault events and summary levels
    input wire psf_pkg::psf_evt_t evt_i,
    input wire psf_pkg::psf_sum_t sum_i,
    // Alert and decoded values
    output logic alert_line_n_o,
    output logic [15:0] vout_set_o,
    output logic [4:0] vout_exp_o,
    output logic [15:0] vout_cal_o,
    output logic [15:0] iout_cal_o,
    output logic [14:0] time_ms_o
);
    psf_pkg::psf_state_t q_r;
    psf_pkg::psf_state_t q_nxt;

    // Summary word from detail registers and summary levels
    function automatic logic [15:0] build_word(input psf_pkg::psf_evt_t d,
                                               input psf_pkg::psf_sum_t s);
        logic [15:0] w;
        w[15] = |d.vout;
        w[14] = |d.iout;
        w[13] = s.input_flt;
        w[12] = |d.ext;
        w[11] = s.pg_n;
        w[10] = s.fans;
        w[9] = s.other;
        w[8] = s.unknown;
        w[7] = s.busy;
        w[6] = s.off;
        w[5] = d.vout[`PSF_VOUT_OV];
        w[4] = d.iout[`PSF_IOUT_OC];
        w[3] = s.vin_uv;
        w[2] = |d.temp;
        w[1] = |d.cml;
        w[0] = |w[15:8];
        return w;
    endfunction

    // General linear word to internal 16-bit value, clamped at both ends
    function automatic logic [15:0] lin11_dec(input logic [15:0] w);
        logic signed [10:0] m;
        logic signed [4:0] e;
        logic signed [47:0] v;
        m = w[10:0];
        e = w[15:11];
        v = 48'(m);
        if (e >= 0) begin
            v = v <<< e;
        end else begin
            v = v >>> (-e);
        end
        if (v < 0) begin
            return 16'h0000;
        end else if (v > 48'sh0000_0000_ffff) begin
            return 16'hffff;
        end
        return v[15:0];
    endfunction

    // Internal value back to a general linear word
    function automatic logic [15:0] lin11_enc(input logic [15:0] v);
        logic [4:0] e;
        logic [15:0] m;
        e = 5'h00;
        m = v;
        for (int i = 0; i < 6; i++) begin
            if (m > 16'(`PSF_LIN11_MANT_MAX)) begin
                m = m >> 1;
                e = e + 5'h01;
            end
        end
        return {e, m[10:0]};
    endfunction

    // Eight-bit time code to milliseconds
    function automatic logic [14:0] time_dec(input logic [7:0] c);
        logic [14:0] m;
        m = {9'h000, c[5:0]};
        case (c[7:6])
            2'b00: return m;
            2'b01: return m << 3;
            2'b10: return m << 6;
            2'b11: return m << 9;
            default: return 15'h0000;
        endcase
    endfunction

    logic clr;
    logic wr_ok;
    logic bad_cmd;
    logic bad_data;
    logic known;
    logic writable;
    logic signed [15:0] cal_in;

    // Command decode and register update
    always_comb begin
        q_nxt = q_r;
        clr = wr_i && cmd_i == `PSF_CMD_CLEAR_FAULTS;
        known = 1'b1;
        writable = 1'b0;
        bad_data = 1'b0;
        cal_in = wdata_i;
        case (cmd_i)
            `PSF_CMD_CLEAR_FAULTS, `PSF_CMD_VEXP_MODE, `PSF_CMD_VOUT_SET,
            `PSF_CMD_VOUT_CAL, `PSF_CMD_IOUT_CAL, `PSF_CMD_TIME: begin
                writable = 1'b1;
            end
            `PSF_CMD_WORD, `PSF_CMD_VOUT_ST, `PSF_CMD_IOUT_ST,
            `PSF_CMD_TEMP_ST, `PSF_CMD_CML_ST, `PSF_CMD_EXT_ST,
            `PSF_CMD_TIME_MS: begin
                writable = 1'b0;
            end
            default: begin
                known = 1'b0;
            end
        endcase
        wr_ok = wr_i && writable;
        bad_cmd = (wr_i && !writable) || (rd_i && !known);
        // Writes to parameter registers
        if (wr_ok) begin
            case (cmd_i)
                `PSF_CMD_VEXP_MODE: begin
                    q_nxt.vexp = wdata_i[`PSF_VEXP_W-1:0];
                end
                `PSF_CMD_VOUT_SET: begin
                    if (wdata_i > VOUT_LIMIT) begin
                        bad_data = 1'b1;
                    end else begin
                        q_nxt.vset = wdata_i;
                    end
                end
                `PSF_CMD_VOUT_CAL: begin
                    if (cal_in > $signed(CAL_LIMIT)) begin
                        q_nxt.vcal = CAL_LIMIT;
                    end else if (cal_in < -$signed(CAL_LIMIT)) begin
                        q_nxt.vcal = 16'(-$signed(CAL_LIMIT));
                    end else begin
                        q_nxt.vcal = wdata_i;
                    end
                end
                `PSF_CMD_IOUT_CAL: q_nxt.ical = lin11_dec(wdata_i);
                `PSF_CMD_TIME: q_nxt.tcode = wdata_i[7:0];
                default: q_nxt.tcode = q_r.tcode;
            endcase
        end
        q_nxt.tms = time_dec(q_nxt.tcode);
        // Sticky status: a set in the clear cycle wins
        q_nxt.st.vout = ((clr ? 8'h00 : q_r.st.vout) | evt_i.vout)
                        & `PSF_VOUT_MASK;
        q_nxt.st.iout = ((clr ? 8'h00 : q_r.st.iout) | evt_i.iout)
                        & `PSF_IOUT_MASK;
        q_nxt.st.temp = ((clr ? 8'h00 : q_r.st.temp) | evt_i.temp)
                        & `PSF_TEMP_MASK;
        q_nxt.st.cml = ((clr ? 8'h00 : q_r.st.cml) | evt_i.cml
                        | {bad_cmd, bad_data, 6'h00}) & `PSF_CML_MASK;
        q_nxt.st.ext = ((clr ? 48'h0 : q_r.st.ext) | evt_i.ext)
                       & `PSF_EXT_MASK;
        q_nxt.word = build_word(q_nxt.st, sum_i);
        q_nxt.alert_n = !(|q_nxt.word);
        // Read answer
        q_nxt.rvalid = rd_i && known;
        q_nxt.nack = bad_cmd;
        q_nxt.rdata = 48'h0;
        if (rd_i) begin
            case (cmd_i)
                `PSF_CMD_VEXP_MODE:
                    q_nxt.rdata = {40'h0, `PSF_VEXP_LINEAR, q_r.vexp};
                `PSF_CMD_VOUT_SET: q_nxt.rdata = {32'h0, q_r.vset};
                `PSF_CMD_VOUT_CAL: q_nxt.rdata = {32'h0, q_r.vcal};
                `PSF_CMD_IOUT_CAL: q_nxt.rdata = {32'h0, lin11_enc(q_r.ical)};
                `PSF_CMD_WORD: q_nxt.rdata = {32'h0, q_r.word};
                `PSF_CMD_VOUT_ST: q_nxt.rdata = {40'h0, q_r.st.vout};
                `PSF_CMD_IOUT_ST: q_nxt.rdata = {40'h0, q_r.st.iout};
                `PSF_CMD_TEMP_ST: q_nxt.rdata = {40'h0, q_r.st.temp};
                `PSF_CMD_CML_ST: q_nxt.rdata = {40'h0, q_r.st.cml};
                `PSF_CMD_EXT_ST: q_nxt.rdata = q_r.st.ext;
                `PSF_CMD_TIME: q_nxt.rdata = {40'h0, q_r.tcode};
                `PSF_CMD_TIME_MS: q_nxt.rdata = {33'h0, q_r.tms};
                default: q_nxt.rdata = 48'h0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            q_r <= '0;
            q_r.alert_n <= 1'b1;
            q_r.vexp <= `PSF_RST_VEXP;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs straight from the state register
    assign rdata_o = q_r.rdata;
    assign rvalid_o = q_r.rvalid;
    assign nack_o = q_r.nack;
    assign alert_line_n_o = q_r.alert_n;
    assign vout_set_o = q_r.vset;
    assign vout_exp_o = q_r.vexp;
    assign vout_cal_o = q_r.vcal;
    assign iout_cal_o = q_r.ical;
    assign time_ms_o = q_r.tms;

    property p_alert_follows;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (|q_r.st) |-> !alert_line_n_o;
    endproperty
    a_alert_follows: assert property (p_alert_follows)
        else $error("alert line high with a status bit set");

    property p_vexp_write;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_i && cmd_i == `PSF_CMD_VEXP_MODE)
        |=> (vout_exp_o == $past(wdata_i[4:0]));
    endproperty
    a_vexp_write: assert property (p_vexp_write)
        else $error("exponent not taken from low five bits");

    property p_mode_fixed;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (rd_i && cmd_i == `PSF_CMD_VEXP_MODE) |=> (rdata_o[7:5] == 3'h0);
    endproperty
    a_mode_fixed: assert property (p_mode_fixed)
        else $error("exponent mode bits not linear");

    property p_vset_range;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_i && cmd_i == `PSF_CMD_VOUT_SET && wdata_i > VOUT_LIMIT)
        |=> ($stable(vout_set_o) && q_r.st.cml[`PSF_CML_BAD_DATA]);
    endproperty
    a_vset_range: assert property (p_vset_range)
        else $error("out-of-range voltage accepted");

    property p_cal_clamp;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ##1 ($signed(vout_cal_o) <= $signed(CAL_LIMIT)
             && $signed(vout_cal_o) >= -$signed(CAL_LIMIT));
    endproperty
    a_cal_clamp: assert property (p_cal_clamp)
        else $error("calibration offset beyond limit");

    property p_time_zero;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_i && cmd_i == `PSF_CMD_TIME && wdata_i[5:0] == 6'h00)
        |=> (time_ms_o == 15'h0000);
    endproperty
    a_time_zero: assert property (p_time_zero)
        else $error("zero mantissa gave nonzero time");

    property p_time_mult;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wr_i && cmd_i == `PSF_CMD_TIME && wdata_i[7:6] == 2'b11)
        |=> (time_ms_o == 15'($past(wdata_i[5:0])) * 15'd512);
    endproperty
    a_time_mult: assert property (p_time_mult)
        else $error("largest multiplier wrong");

    property p_word_iout;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        evt_i.iout[`PSF_IOUT_OC]
        |=> (q_r.word[14] && q_r.word[4] && q_r.word[0]);
    endproperty
    a_word_iout: assert property (p_word_iout)
        else $error("summary bits do not follow current byte");

    property p_ext_sticky;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        evt_i.ext[`PSF_EXT_INPUT_LSB] |=> q_r.st.ext[`PSF_EXT_INPUT_LSB];
    endproperty
    a_ext_sticky: assert property (p_ext_sticky)
        else $error("input fault one lost or not at bit 16");

    c_alert: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $fell(alert_line_n_o));
    c_clear: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(alert_line_n_o));
    c_badcmd: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        nack_o);
endmodule
